// ==== crs_scheduler.sv ====
// conversion sequencer with rate register and address pins
`timescale 1ns/1ps
module crs_scheduler import crs_pkg::*; #(
   parameter int TICK_CYCLES = `CRS_TICK_CYCLES
) (
   input wire logic ref_clk,          // 50 MHz clock
   input wire logic arst_n,           // async reset, active low
   input wire crs_reg_req_s reg_req,  // decoded register access
   output logic [7:0] reg_rdata,      // read data, valid after rd
   input wire logic [3:0] chan_enable, // local, ext1, ext2, ext3
   input wire logic halt_conversions, // shutdown control bit
   input wire logic one_shot_req,     // one-shot write pulse
   input wire logic addr_select_high, // address pin, async
   input wire logic addr_select_low,  // address pin, async
   output logic [6:0] slave_addr,     // selected slave address
   output logic conv_active,          // a channel is converting
   output logic [1:0] conv_channel,   // channel being converted
   output logic chan_done,            // pulse at end of a channel
   output logic [2:0] rate_effective  // code in use this sequence
);
   logic rst_meta_ff;
   logic rst_n;
   logic tick;
   crs_sched_s cur_ff;
   crs_sched_s nxt_s;
   logic [2:0] first_pick;
   logic [2:0] next_pick;
   logic [14:0] period_ms;

   // reset release through two flops
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta_ff <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_n <= rst_meta_ff;
      end
   end

   crs_tick_div #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_div (
      .clk(ref_clk),
      .rst_n(rst_n),
      .tick(tick)
   );

   // lowest enabled channel at or above start; bit 2 says found
   function automatic logic [2:0] crs_find(input logic [3:0] en, input logic [2:0] start);
      logic [2:0] res;
      res = 3'b000;
      for (int i = 3; i >= 0; i--) begin
         if (en[i] && (3'(i) >= start)) begin
            res = {1'b1, 2'(i)};
         end
      end
      return res;
   endfunction

   assign first_pick = crs_find(chan_enable, 3'h0);
   assign next_pick = crs_find(chan_enable, {1'b0, cur_ff.ch} + 3'h1);
   // period halves per code step; it counts from sequence start, conversion time included
   assign period_ms = `CRS_SLOWEST_PERIOD_MS >> cur_ff.rate_eff;

   always_comb begin
      nxt_s = cur_ff;
      nxt_s.chan_done = 1'b0;
      nxt_s.a_meta = {addr_select_high, addr_select_low};
      nxt_s.a_sync = cur_ff.a_meta;
      nxt_s.slave_addr = {`CRS_ADDR_BASE_HI, cur_ff.a_sync};
      if (reg_req.wr && reg_req.ptr == `CRS_RATE_PTR) begin
         nxt_s.rate_reg = reg_req.wdata;
      end
      if (reg_req.rd) begin
         nxt_s.rdata = (reg_req.ptr == `CRS_RATE_PTR) ? cur_ff.rate_reg : `CRS_RD_UNMAPPED;
      end
      // elapsed time since sequence start, saturating
      if (tick && cur_ff.seq_ms != `CRS_SEQ_MS_MAX) begin
         nxt_s.seq_ms = cur_ff.seq_ms + 15'h0001;
      end
      unique case (cur_ff.state)
         CRS_CONV: begin
            if (tick) begin
               if (cur_ff.tick_cnt == `CRS_CONV_MS - 7'h01) begin
                  nxt_s.tick_cnt = 7'h00;
                  nxt_s.chan_done = 1'b1;
                  if (next_pick[2]) begin
                     nxt_s.ch = next_pick[1:0];
                  end else begin
                     // code is sampled only here, so mid-sequence writes wait
                     nxt_s.rate_eff = (cur_ff.rate_reg > 8'h07) ? `CRS_RATE_MAX
                                                                : cur_ff.rate_reg[2:0];
                     nxt_s.state = halt_conversions ? CRS_HALT : CRS_WAIT;
                  end
               end else begin
                  nxt_s.tick_cnt = cur_ff.tick_cnt + 7'h01;
               end
            end
         end
         CRS_WAIT: begin
            // idle stretches the sequence to the period; a sequence longer
            // than the period restarts at once, which gives the slowed rates
            if (one_shot_req || (!halt_conversions && cur_ff.seq_ms >= period_ms)) begin
               nxt_s.seq_ms = 15'h0000;
               nxt_s.tick_cnt = 7'h00;
               nxt_s.ch = first_pick[1:0];
               nxt_s.state = first_pick[2] ? CRS_CONV : CRS_WAIT;
            end else if (halt_conversions) begin
               nxt_s.state = CRS_HALT;
            end
         end
         CRS_HALT: begin
            if (one_shot_req || !halt_conversions) begin
               nxt_s.seq_ms = 15'h0000;
               nxt_s.tick_cnt = 7'h00;
               nxt_s.ch = first_pick[1:0];
               nxt_s.state = first_pick[2] ? CRS_CONV : CRS_WAIT;
            end
         end
         default: begin
            nxt_s.state = CRS_WAIT;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cur_ff <= '0;
         cur_ff.state <= CRS_WAIT;
         // saturated so the first sequence starts right after reset
         cur_ff.seq_ms <= `CRS_SEQ_MS_MAX;
         cur_ff.rate_reg <= `CRS_RATE_RESET;
         cur_ff.rate_eff <= `CRS_RATE_MAX;
         cur_ff.slave_addr <= {`CRS_ADDR_BASE_HI, 2'b00};
      end else begin
         cur_ff <= nxt_s;
      end
   end

   assign reg_rdata = cur_ff.rdata;
   assign slave_addr = cur_ff.slave_addr;
   assign conv_active = (cur_ff.state == CRS_CONV);
   assign conv_channel = cur_ff.ch;
   assign chan_done = cur_ff.chan_done;
   assign rate_effective = cur_ff.rate_eff;

   a_rate_write_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (reg_req.wr && reg_req.ptr == `CRS_RATE_PTR) ##1
      (reg_req.rd && reg_req.ptr == `CRS_RATE_PTR && !reg_req.wr)
      |=> reg_rdata == $past(reg_req.wdata, 2))
      else $error("rate register did not return written value");

   a_conv_fixed_len: assert property (@(posedge ref_clk) disable iff (!rst_n)
      chan_done |-> $past(cur_ff.tick_cnt) == `CRS_CONV_MS - 7'h01 && $past(tick))
      else $error("channel conversion length wrong");

   a_oneshot_starts: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (cur_ff.state == CRS_WAIT && one_shot_req && chan_enable != 4'h0)
      |=> conv_active && cur_ff.seq_ms == 15'h0000)
      else $error("one-shot did not start a sequence");

   a_idle_holds: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (cur_ff.state == CRS_WAIT && !one_shot_req && !halt_conversions
       && cur_ff.seq_ms < period_ms) |=> cur_ff.state == CRS_WAIT)
      else $error("idle ended before the period");

   a_restart_period: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (cur_ff.state == CRS_WAIT && !one_shot_req ##1 cur_ff.state == CRS_CONV)
      |-> $past(cur_ff.seq_ms) >= $past(period_ms))
      else $error("sequence restarted early");

   a_addr_follow: assert property (@(posedge ref_clk) disable iff (!rst_n)
      ##3 slave_addr == {`CRS_ADDR_BASE_HI, $past(addr_select_high, 3), $past(addr_select_low, 3)})
      else $error("slave address does not follow pins");

   a_chan_order: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (conv_active ##1 conv_active && conv_channel != $past(conv_channel))
      |-> conv_channel > $past(conv_channel) && $past(chan_done == 1'b0) && chan_done)
      else $error("channel order broken");

   a_halt_stays: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (cur_ff.state == CRS_HALT && halt_conversions && !one_shot_req)
      |=> cur_ff.state == CRS_HALT)
      else $error("halted scheduler started without one-shot");

   a_rate_held: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (conv_active ##1 conv_active) |-> $stable(rate_effective))
      else $error("rate changed inside a sequence");
endmodule

// ==== crs_defines.svh ====
// constants for the conversion rate scheduler
// Overview of operation
// - rate register at pointer 0Bh, resets 07h
// - rate alters idle time, not conversion length
// - one-shot during idle starts sequence immediately
// - codes 0..7 give 0.0625 to 8 per second
// - code 6 slows with three or four channels
// - code 7 slows with two or more channels
// - address pins select the bus slave address
// - local, ext1, ext2, ext3, skip disabled, idle
// - halt stops after sequence; one-shot runs one
`ifndef CRS_DEFINES_SVH
`define CRS_DEFINES_SVH

`define CRS_RATE_PTR 8'h0B
`define CRS_RATE_RESET 8'h07
`define CRS_RATE_MAX 3'h7
`define CRS_RD_UNMAPPED 8'h00

// timebase: 1 ms tick from a 20 ns clock
`define CRS_CLK_PERIOD_NS 20
`define CRS_TICK_PERIOD_NS 1000000
`define CRS_TICK_CYCLES (`CRS_TICK_PERIOD_NS / `CRS_CLK_PERIOD_NS)

// one channel conversion, in ms ticks
`define CRS_CONV_MS 7'h7D
// sequence period for code 0 (0.0625 per second), in ms
`define CRS_SLOWEST_PERIOD_MS 15'h3E80
`define CRS_SEQ_MS_MAX 15'h7FFF

// upper slave address bits; arbitrary value
`define CRS_ADDR_BASE_HI 5'h13

`endif

// ==== crs_pkg.sv ====
// types shared by the conversion rate scheduler
`include "crs_defines.svh"
package crs_pkg;

   typedef enum logic [1:0] {
      CRS_WAIT = 2'b00,
      CRS_CONV = 2'b01,
      CRS_HALT = 2'b11
   } crs_state_e;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] ptr;
      logic [7:0] wdata;
   } crs_reg_req_s;

   typedef struct packed {
      crs_state_e state;
      logic [1:0] ch;
      logic [6:0] tick_cnt;
      logic [14:0] seq_ms;
      logic [7:0] rate_reg;
      logic [2:0] rate_eff;
      logic [7:0] rdata;
      logic chan_done;
      logic [1:0] a_meta;
      logic [1:0] a_sync;
      logic [6:0] slave_addr;
   } crs_sched_s;

   typedef struct packed {
      logic [15:0] cnt;
      logic tick;
   } crs_div_s;

endpackage

// ==== crs_tick_div.sv ====
// divider making the one-cycle millisecond tick
`timescale 1ns/1ps
module crs_tick_div import crs_pkg::*; #(
   parameter int TICK_CYCLES = `CRS_TICK_CYCLES
) (
   input wire logic clk,   // system clock
   input wire logic rst_n, // synchronised reset
   output logic tick       // one-cycle pulse per period
);
   crs_div_s cur_ff;
   crs_div_s nxt_div;

   always_comb begin
      nxt_div = cur_ff;
      nxt_div.tick = 1'b0;
      if (cur_ff.cnt == 16'(TICK_CYCLES - 1)) begin
         nxt_div.cnt = 16'h0000;
         nxt_div.tick = 1'b1;
      end else begin
         nxt_div.cnt = cur_ff.cnt + 16'h0001;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cur_ff <= '0;
      end else begin
         cur_ff <= nxt_div;
      end
   end

   assign tick = cur_ff.tick;
endmodule

// ==== crs_host_model.sv ====
// host-side model driving register accesses and control pins
`timescale 1ns/1ps
module crs_host_model import crs_pkg::*; (
   input wire logic ref_clk,      // clock
   output crs_reg_req_s reg_req,  // register access
   output logic one_shot_req,     // one-shot pulse
   output logic halt_conversions, // shutdown bit
   output logic [3:0] chan_enable, // channel enables
   output logic [1:0] addr_pins   // {high, low} straps
);
   initial begin
      reg_req = '0;
      one_shot_req = 1'b0;
      halt_conversions = 1'b0;
      chan_enable = 4'hF;
      addr_pins = 2'h0;
   end
   task automatic acc(input logic w, input logic [7:0] p, input logic [7:0] d);
      @(negedge ref_clk);
      reg_req <= '{wr: w, rd: !w, ptr: p, wdata: d};
      @(negedge ref_clk);
      // released bus shows inverted data, not the last value
      reg_req <= '{wr: 1'b0, rd: 1'b0, ptr: ~p, wdata: ~d};
   endtask
   // write, then read the same pointer in the very next cycle
   task automatic wr_rd(input logic [7:0] p, input logic [7:0] d);
      @(negedge ref_clk);
      reg_req <= '{wr: 1'b1, rd: 1'b0, ptr: p, wdata: d};
      @(negedge ref_clk);
      reg_req <= '{wr: 1'b0, rd: 1'b1, ptr: p, wdata: ~d};
      @(negedge ref_clk);
      reg_req <= '{wr: 1'b0, rd: 1'b0, ptr: ~p, wdata: ~d};
   endtask
   task automatic pulse();
      @(negedge ref_clk);
      one_shot_req <= 1'b1;
      @(negedge ref_clk);
      one_shot_req <= 1'b0;
   endtask
   task automatic set_ctl(input logic [3:0] en, input logic h, input logic [1:0] a);
      @(negedge ref_clk);
      chan_enable <= en;
      halt_conversions <= h;
      addr_pins <= a;
   endtask
endmodule

// ==== testbench.sv ====
// self-checking bench for the conversion rate scheduler
`timescale 1ns/1ps
`include "crs_defines.svh"
module testbench;
   import crs_pkg::*;
   localparam int TC = 4;
   localparam int CH = 125 * TC;
   localparam logic [7:0] CODES [10] = '{8'h07, 8'h07, 8'h07, 8'h06, 8'h06, 8'h06, 8'h05,
      8'h04, 8'h03, 8'hFF};
   localparam logic [3:0] ENS [10] = '{4'h1, 4'h3, 4'hD, 4'h3, 4'h7, 4'hF, 4'h1, 4'h2,
      4'h1, 4'h1};
   localparam int MS [10] = '{125, 250, 375, 250, 375, 500, 500, 1000, 2000, 125};
   logic ref_clk = 1'b0;
   logic arst_n = 1'b0;
   crs_reg_req_s reg_req;
   logic one_shot_req, halt_conversions, conv_active, chan_done;
   logic [3:0] chan_enable;
   logic [1:0] pins, conv_channel;
   logic [7:0] reg_rdata;
   logic [6:0] slave_addr;
   logic [2:0] rate_effective;
   int mismatches = 0;
   int total_checks = 0;
   logic [7:0] rd_q[$];
   logic [1:0] ch_q[$];
   logic rd_pend = 1'b0;
   logic prev_act = 1'b0;
   logic [1:0] prev_ch = 2'h0;
   int run = 0;
   logic ended = 1'b0;
   always #10 ref_clk = ~ref_clk;
   crs_host_model host (.ref_clk(ref_clk), .reg_req(reg_req), .one_shot_req(one_shot_req),
      .halt_conversions(halt_conversions), .chan_enable(chan_enable), .addr_pins(pins));
   crs_scheduler #(.TICK_CYCLES(TC)) i_crs_scheduler (.ref_clk(ref_clk), .arst_n(arst_n),
      .reg_req(reg_req), .reg_rdata(reg_rdata), .chan_enable(chan_enable),
      .halt_conversions(halt_conversions), .one_shot_req(one_shot_req),
      .addr_select_high(pins[1]), .addr_select_low(pins[0]), .slave_addr(slave_addr),
      .conv_active(conv_active), .conv_channel(conv_channel), .chan_done(chan_done),
      .rate_effective(rate_effective));
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic check_near(input int got, input int exp, input int tol);
      total_checks++;
      if (got < exp - tol || got > exp + tol) begin
         mismatches++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wait_act(input logic lvl, input int lim);
      int n;
      n = 0;
      while (conv_active !== lvl) begin
         @(negedge ref_clk);
         n++;
         if (n > lim) begin
            mismatches++;
            give_verdict();
         end
      end
   endtask
   task automatic rd(input logic [7:0] p, input logic [7:0] exp);
      rd_q.push_back(exp);
      host.acc(1'b0, p, 8'h00);
   endtask
   // channel list is queued only while idle so a running sequence never eats it
   task automatic measure(input logic [3:0] en, input int exp);
      time t0;
      wait_act(1'b0, 40 * CH);
      for (int c = 0; c < 4; c++)
         if (en[c])
            ch_q.push_back(2'(c));
      wait_act(1'b1, 40 * CH);
      t0 = $time;
      wait_act(1'b0, 40 * CH);
      wait_act(1'b1, 40 * CH);
      check_near(int'(($time - t0) / 20), exp, 8);
   endtask
   // outputs are looked at mid-cycle, well away from the edge that moves them
   always @(negedge ref_clk) begin
      if (rd_pend && rd_q.size() > 0)
         check_val(reg_rdata, rd_q.pop_front());
      rd_pend = reg_req.rd;
      ended = prev_act && (conv_active !== 1'b1 || conv_channel !== prev_ch);
      if (ended)
         check_near(run, CH, 6);
      if (ended || chan_done !== 1'b0)
         check_val({7'h0, chan_done}, {7'h0, ended});
      if (conv_active === 1'b1 && (!prev_act || conv_channel !== prev_ch)) begin
         run = 1;
         if (ch_q.size() > 0)
            check_val({6'h0, conv_channel}, {6'h0, ch_q.pop_front()});
      end else
         run++;
      prev_act = (conv_active === 1'b1);
      prev_ch = conv_channel;
   end
   initial begin
      logic [7:0] d;
      void'($urandom(32'h570E2551));
      repeat (4) @(negedge ref_clk);
      arst_n = 1'b1;
      repeat (3) @(negedge ref_clk);
      rd(8'h0B, 8'h07);
      rd(8'h09, 8'h00);
      for (int i = 0; i < 4; i++) begin
         d = 8'($urandom);
         rd_q.push_back(d);
         host.wr_rd(8'h0B, d);
         host.set_ctl(4'hF, 1'b0, 2'($urandom));
         repeat (4) @(negedge ref_clk);
         check_val({1'b0, slave_addr}, {1'b0, `CRS_ADDR_BASE_HI, pins});
      end
      for (int i = 0; i < 10; i++) begin
         host.acc(1'b1, 8'h0B, CODES[i]);
         host.set_ctl(ENS[i], 1'b0, 2'h1);
         measure(ENS[i], MS[i] * TC);
         check_val({5'h0, rate_effective}, CODES[i] > 8'h07 ? 8'h07 : CODES[i]);
      end
      // slowest code keeps the idle long enough to see a one-shot cut it short
      host.acc(1'b1, 8'h0B, 8'h00);
      host.set_ctl(4'h1, 1'b1, 2'h2);
      wait_act(1'b1, 2 * CH);
      wait_act(1'b0, 2 * CH);
      repeat (CH + 50) @(negedge ref_clk);
      check_val({7'h0, conv_active}, 8'h00);
      check_val({5'h0, rate_effective}, 8'h00);
      host.pulse();
      check_val({7'h0, conv_active}, 8'h01);
      wait_act(1'b0, 2 * CH);
      repeat (CH + 50) @(negedge ref_clk);
      check_val({7'h0, conv_active}, 8'h00);
      host.set_ctl(4'h1, 1'b0, 2'h2);
      wait_act(1'b1, 20);
      wait_act(1'b0, 2 * CH);
      repeat (100) @(negedge ref_clk);
      host.pulse();
      check_val({7'h0, conv_active}, 8'h01);
      // codes 2 and 1: idle far too long to time, so a one-shot cuts it
      for (int c = 2; c > 0; c--) begin
         host.acc(1'b1, 8'h0B, 8'(c));
         wait_act(1'b0, 2 * CH);
         check_val({5'h0, rate_effective}, 8'(c));
         repeat (100) @(negedge ref_clk);
         check_val({7'h0, conv_active}, 8'h00);
         host.pulse();
         check_val({7'h0, conv_active}, 8'h01);
      end
      give_verdict();
   end
endmodule
